// [hw/pdm_pkg.sv]
// Constants, register layout and types for the power-down mode sequencer.
// Assumes a single 40 MHz clock and a classic Wishbone register slave.
// What this block does
// - Sleep wakes on low IRQs or timer A
// - Wake blocked by CPU mask or disable
// - Reset pin low abandons sleep, resets CPU
// - Sleep with standby set, watch clear: standby
// - Standby IRQ wake: restart clock, wait, resume
// - Reset pin in deep modes starts clock
// - Watch entry from active or subactive
// - Watch halts system clock except timer A
// - Watch wake: active after wait, or subactive
// - Subactive runs CPU on subclock
// - Sleep in subactive with direct clear: watch
// - Direct transfer requests interrupt, waits, active
// - Direct transfer blocked by mask or disable
// - Control one: 8 bits, fixed field layout
// - Standby-select writable only in active mode
// - Wait select encodes 8192 to 131072 states
// - Standby-select stays set after standby wake
// - Direct-transfer bit writable only in subactive
package pdm_pkg;
	localparam logic [15:0] ADDR_CTRL_ONE = 16'hFFF0;
	localparam logic [15:0] ADDR_CTRL_TWO = 16'hFFF1;
	localparam logic [15:0] ADDR_MODE = 16'hFFF2;
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'hF4;
	localparam int BIT_STBY = 7;
	localparam int BIT_STS_HI = 6;
	localparam int BIT_STS_LO = 4;
	localparam int BIT_LOW_SPEED_SELECT = 3;
	localparam int BIT_DIRECT_TRANSFER_SELECT = 3;
	localparam logic [7:0] CTRL_ONE_WMASK = 8'hFC;
	localparam logic [7:0] CTRL_TWO_FIXED = 8'hF4;
	localparam logic [7:0] CTRL_TWO_RWMASK = 8'h03;
	localparam int WAIT_W = 18;
	localparam logic [WAIT_W-1:0] WAIT_0 = 18'h02000;
	localparam logic [WAIT_W-1:0] WAIT_1 = 18'h04000;
	localparam logic [WAIT_W-1:0] WAIT_2 = 18'h08000;
	localparam logic [WAIT_W-1:0] WAIT_3 = 18'h10000;
	localparam logic [WAIT_W-1:0] WAIT_4 = 18'h20000;

	typedef enum logic [2:0] {
		M_ACTIVE, M_SLEEP, M_STANDBY, M_WATCH, M_SUBACT, M_SETTLE, M_RESET
	} mode_e;

	typedef struct packed {
		logic ext_irq_zero;
		logic ext_irq_one;
		logic timerA;
		logic direct;
	} wake_s;
endpackage

// [hw/settle_counter.sv]
// Oscillator settling counter: counts system clock states up to a limit.
// Assumes start is a one-cycle pulse and the limit is held while counting.
`timescale 1ns/1ps
`default_nettype none
module settle_counter #(
	parameter int W = 18
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [W-1:0] limit,
	output logic done
);
	logic [W-1:0] count_r;
	logic run_r;
	wire reached = run_r && (count_r == limit - W'(1));

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
			run_r <= 1'b0;
		end else if (start) begin
			count_r <= '0;
			run_r <= 1'b1;
		end else if (run_r) begin
			count_r <= count_r + W'(1);
			run_r <= !reached;
		end
	end

	assign done = reached;
endmodule
`default_nettype wire

// [hw/power_down_mode_sequencer.sv]
// Power-down mode sequencer with two control registers on Wishbone.
// Assumes CPU pulses sleepExec on a sleep instruction; wake inputs are levels.
`timescale 1ns/1ps
`default_nettype none
module power_down_mode_sequencer
	import pdm_pkg::*;
#(
	parameter int WAIT_SCALE = 1
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [15:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	output logic [7:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic sleepExec,
	input wire logic watchSelect,
	input wire logic intMask,
	input wire wake_s wakeReq,
	input wire wake_s wakeEnable,
	input wire logic reset_pin_n,
	output logic sysClkRun,
	output logic cpuSubclock,
	output logic cpuHalt,
	output logic cpuReset,
	output logic periphHalt,
	output logic portsFloat,
	output logic timerABase,
	output logic wakeIntStart,
	output logic directIntReq,
	output mode_e modeOut
);
	logic rstMeta_r;
	logic rst_n;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rst_n <= rstMeta_r;
		end
	end

	mode_e mode_r, mode_nxt;
	logic [7:0] ctrlOne_r;
	logic [7:0] ctrlTwo_r;
	logic settleToSub_r;
	logic settleIsReset_r;
	logic ack_r;
	logic [7:0] rdat_r;
	logic wakeInt_r, wakeInt_nxt;
	logic direct_r, direct_nxt;

	wire standbySel = ctrlOne_r[BIT_STBY];
	wire lowSpeed = ctrlOne_r[BIT_LOW_SPEED_SELECT];
	wire directSel = ctrlTwo_r[BIT_DIRECT_TRANSFER_SELECT];
	wire [2:0] waitSel = ctrlOne_r[BIT_STS_HI:BIT_STS_LO];

	// Masked wake sources; the CPU mask blocks every one of them
	wire [3:0] wakeOk = intMask ? 4'h0 : (wakeReq & wakeEnable);
	wire okIrq0 = wakeOk[3];
	wire okIrq1 = wakeOk[2];
	wire okTimer = wakeOk[1];
	// Direct transfer needs no outside request: the sleep itself raises it
	wire okDirect = !intMask && wakeEnable.direct;

	logic [WAIT_W-1:0] waitLimit;
	always_comb begin
		unique case (waitSel)
			3'h0: waitLimit = WAIT_0;
			3'h1: waitLimit = WAIT_1;
			3'h2: waitLimit = WAIT_2;
			3'h3: waitLimit = WAIT_3;
			default: waitLimit = WAIT_4;
		endcase
	end
	// Scaling only shortens simulation; default keeps the real count
	wire [WAIT_W-1:0] scaledLimit = WAIT_W'(waitLimit / WAIT_SCALE);

	logic startSettle;
	logic settleDone;
	settle_counter #(.W(WAIT_W)) u_settle (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(startSettle),
		.limit(scaledLimit),
		.done(settleDone)
	);

	logic nextToSub, nextIsReset;
	always_comb begin
		mode_nxt = mode_r;
		startSettle = 1'b0;
		nextToSub = settleToSub_r;
		nextIsReset = settleIsReset_r;
		wakeInt_nxt = 1'b0;
		direct_nxt = 1'b0;
		unique case (mode_r)
			M_ACTIVE: begin
				if (!reset_pin_n) begin
					mode_nxt = M_RESET;
				end else if (sleepExec) begin
					if (!standbySel) begin
						mode_nxt = M_SLEEP;
					end else if (watchSelect) begin
						mode_nxt = M_WATCH;
					end else begin
						mode_nxt = M_STANDBY;
					end
				end
			end
			M_SLEEP: begin
				if (!reset_pin_n) begin
					mode_nxt = M_RESET;
				end else if (okIrq0 || okIrq1 || okTimer) begin
					mode_nxt = M_ACTIVE;
					wakeInt_nxt = 1'b1;
				end
			end
			M_STANDBY: begin
				if (!reset_pin_n) begin
					mode_nxt = M_SETTLE;
					startSettle = 1'b1;
					nextIsReset = 1'b1;
					nextToSub = 1'b0;
				end else if (okIrq0 || okIrq1) begin
					mode_nxt = M_SETTLE;
					startSettle = 1'b1;
					nextIsReset = 1'b0;
					nextToSub = 1'b0;
				end
			end
			M_WATCH: begin
				if (!reset_pin_n) begin
					mode_nxt = M_SETTLE;
					startSettle = 1'b1;
					nextIsReset = 1'b1;
					nextToSub = 1'b0;
				end else if (okIrq0 || okTimer) begin
					if (lowSpeed) begin
						mode_nxt = M_SUBACT;
						wakeInt_nxt = 1'b1;
					end else begin
						mode_nxt = M_SETTLE;
						startSettle = 1'b1;
						nextIsReset = 1'b0;
						nextToSub = 1'b0;
					end
				end
			end
			M_SUBACT: begin
				if (!reset_pin_n) begin
					mode_nxt = M_SETTLE;
					startSettle = 1'b1;
					nextIsReset = 1'b1;
					nextToSub = 1'b0;
				end else if (sleepExec) begin
					// LOW_SPEED_SELECT set blocks direct transfer, so it falls back to watch
					if (!directSel || lowSpeed || !okDirect) begin
						mode_nxt = M_WATCH;
					end else begin
						mode_nxt = M_SETTLE;
						startSettle = 1'b1;
						direct_nxt = 1'b1;
						nextIsReset = 1'b0;
						nextToSub = 1'b1;
					end
				end
			end
			M_SETTLE: begin
				if (settleDone) begin
					if (settleIsReset_r) begin
						mode_nxt = M_RESET;
					end else begin
						mode_nxt = M_ACTIVE;
						wakeInt_nxt = !settleToSub_r;
					end
				end
			end
			M_RESET: begin
				// Reset exception handling starts when the pin rises
				if (reset_pin_n) begin
					mode_nxt = M_ACTIVE;
				end
			end
			default: mode_nxt = M_RESET;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= M_ACTIVE;
			settleToSub_r <= 1'b0;
			settleIsReset_r <= 1'b0;
			wakeInt_r <= 1'b0;
			direct_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			settleToSub_r <= nextToSub;
			settleIsReset_r <= nextIsReset;
			wakeInt_r <= wakeInt_nxt;
			direct_r <= direct_nxt;
		end
	end

	// Mode outputs from flops fed by the next mode: same timing as a decode of mode_r,
	// but clock and reset controls cannot glitch when two state flops change at once
	logic sysClkRun_r;
	logic cpuSubclock_r;
	logic cpuHalt_r;
	logic cpuReset_r;
	logic periphHalt_r;
	logic portsFloat_r;
	logic timerABase_r;

	wire sysClkRun_nxt = (mode_nxt == M_ACTIVE) || (mode_nxt == M_SLEEP)
		|| (mode_nxt == M_RESET);
	wire cpuSubclock_nxt = (mode_nxt == M_SUBACT);
	wire cpuHalt_nxt = (mode_nxt != M_ACTIVE) && (mode_nxt != M_SUBACT);
	wire cpuReset_nxt = (mode_nxt == M_RESET) || (mode_nxt == M_SETTLE && nextIsReset);
	wire periphHalt_nxt = (mode_nxt != M_ACTIVE);
	wire portsFloat_nxt = (mode_nxt == M_STANDBY) || (mode_nxt == M_WATCH)
		|| (mode_nxt == M_SUBACT);
	wire timerABase_nxt = (mode_nxt == M_WATCH) || (mode_nxt == M_SUBACT);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysClkRun_r <= 1'b1;
			cpuSubclock_r <= 1'b0;
			cpuHalt_r <= 1'b0;
			cpuReset_r <= 1'b0;
			periphHalt_r <= 1'b0;
			portsFloat_r <= 1'b0;
			timerABase_r <= 1'b0;
		end else begin
			sysClkRun_r <= sysClkRun_nxt;
			cpuSubclock_r <= cpuSubclock_nxt;
			cpuHalt_r <= cpuHalt_nxt;
			cpuReset_r <= cpuReset_nxt;
			periphHalt_r <= periphHalt_nxt;
			portsFloat_r <= portsFloat_nxt;
			timerABase_r <= timerABase_nxt;
		end
	end

	assign sysClkRun = sysClkRun_r;
	assign cpuSubclock = cpuSubclock_r;
	assign cpuHalt = cpuHalt_r;
	assign cpuReset = cpuReset_r;
	assign periphHalt = periphHalt_r;
	assign portsFloat = portsFloat_r;
	assign timerABase = timerABase_r;
	assign wakeIntStart = wakeInt_r;
	assign directIntReq = direct_r;
	assign modeOut = mode_r;

	// Wishbone slave: one-cycle answer, ack drops the cycle after
	wire req = wb_cyc_i && wb_stb_i && !ack_r;
	wire selOne = (wb_adr_i == ADDR_CTRL_ONE);
	wire selTwo = (wb_adr_i == ADDR_CTRL_TWO);
	wire selMode = (wb_adr_i == ADDR_MODE);
	wire wrOne = req && wb_we_i && wb_sel_i && selOne;
	wire wrTwo = req && wb_we_i && wb_sel_i && selTwo;
	wire inActive = (mode_r == M_ACTIVE);
	wire inSub = (mode_r == M_SUBACT);
	// Standby bit keeps its value outside active mode, so it stays set after wake
	wire stbyNew = inActive ? wb_dat_i[BIT_STBY] : standbySel;
	wire [7:0] oneNew = {stbyNew, wb_dat_i[6:0] & CTRL_ONE_WMASK[6:0]};
	wire dtonNew = inSub ? wb_dat_i[BIT_DIRECT_TRANSFER_SELECT] : directSel;
	wire [7:0] twoNew = CTRL_TWO_FIXED | (wb_dat_i & CTRL_TWO_RWMASK)
		| {4'h0, dtonNew, 3'h0};
	wire [7:0] rdMux = selOne ? ctrlOne_r : selTwo ? ctrlTwo_r
		: selMode ? {5'h00, mode_r} : 8'h00;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlOne_r <= CTRL_ONE_RST;
			ctrlTwo_r <= CTRL_TWO_RST;
			ack_r <= 1'b0;
			rdat_r <= 8'h00;
		end else begin
			ack_r <= req;
			if (req && !wb_we_i) begin
				rdat_r <= rdMux;
			end
			if (wrOne) begin
				ctrlOne_r <= oneNew;
			end
			if (wrTwo) begin
				ctrlTwo_r <= twoNew;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
endmodule
`default_nettype wire

// [tb/power_down_mode_sequencer_sva.sv]
// Port checker for the power-down mode sequencer.
// Assumes it is bound to the top module; settle counts scale by WAIT_SCALE.
`timescale 1ns/1ps
`default_nettype none
module pdm_checker
	import pdm_pkg::*;
#(
	parameter int WAIT_SCALE = 1
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic sleepExec,
	input wire logic intMask,
	input wire wake_s wakeReq,
	input wire wake_s wakeEnable,
	input wire logic reset_pin_n,
	input wire logic sysClkRun,
	input wire logic portsFloat,
	input wire logic timerABase,
	input wire logic cpuSubclock,
	input wire logic wakeIntStart,
	input wire mode_e modeOut
);
	// One cycle of slack on the shortest wait
	localparam int MINW = 8192 / WAIT_SCALE - 2;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic [17:0] cnt_r;
	wire logic settling = modeOut == M_SETTLE;
	wire logic go = !intMask && reset_pin_n && !sleepExec;
	wire logic irqs = |(wakeReq[3:1] & wakeEnable[3:1]);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			cnt_r <= '0;
		else
			cnt_r <= settling ? cnt_r + 18'h00001 : '0;
	end
	sequence s_back;
		##1 modeOut == M_ACTIVE && wakeIntStart;
	endsequence
	property p_sleep_wake;
		modeOut == M_SLEEP && go && irqs |-> s_back;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake missed");
	property p_mask;
		modeOut == M_SLEEP && intMask && reset_pin_n && !sleepExec |=> modeOut == M_SLEEP;
	endproperty
	a_mask: assert property (p_mask) else $error("masked wake left sleep");
	property p_sleep_rst;
		modeOut == M_SLEEP && !reset_pin_n |=> modeOut == M_RESET;
	endproperty
	a_sleep_rst: assert property (p_sleep_rst) else $error("pin low kept sleep");
	property p_stby;
		modeOut == M_STANDBY |-> !sysClkRun && portsFloat;
	endproperty
	a_stby: assert property (p_stby) else $error("standby outputs wrong");
	property p_stby_wake;
		modeOut == M_STANDBY && go && |(wakeReq[3:2] & wakeEnable[3:2]) |=> settling;
	endproperty
	a_stby_wake: assert property (p_stby_wake) else $error("standby wake missed");
	property p_deep_rst;
		modeOut inside {M_STANDBY, M_WATCH, M_SUBACT} && !reset_pin_n |=> settling;
	endproperty
	a_deep_rst: assert property (p_deep_rst) else $error("pin low no settle");
	property p_watch;
		modeOut == M_WATCH |-> !sysClkRun && timerABase;
	endproperty
	a_watch: assert property (p_watch) else $error("watch outputs wrong");
	property p_sub;
		modeOut == M_SUBACT |-> cpuSubclock && portsFloat && timerABase;
	endproperty
	a_sub: assert property (p_sub) else $error("subactive outputs wrong");
	property p_settle;
		settling && cnt_r < MINW |=> settling;
	endproperty
	a_settle: assert property (p_settle) else $error("settle wait too short");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack wrong");
endmodule
bind power_down_mode_sequencer pdm_checker #(.WAIT_SCALE(WAIT_SCALE)) chkI (.sys_clk, .arst_n,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleepExec, .intMask, .wakeReq, .wakeEnable,
	.reset_pin_n, .sysClkRun, .portsFloat, .timerABase, .cpuSubclock, .wakeIntStart, .modeOut);
`default_nettype wire

// [tb/reset_pin_model.sv]
// Reset source on the far side of the sequencer.
// Assumes rstReq is held for two cycles by the bench.
`timescale 1ns/1ps
`default_nettype none
module reset_pin_model
	import pdm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstReq,
	input wire mode_e modeOut,
	output logic reset_pin_n
);
	logic low_r = 1'b0;
	// Clock does not reach the chip at once, so stay low until it settles
	always_ff @(posedge sys_clk) begin
		if (rstReq)
			low_r <= 1'b1;
		else if (modeOut != M_SETTLE)
			low_r <= 1'b0;
	end
	assign reset_pin_n = !low_r;
endmodule
`default_nettype wire

// [tb/power_down_mode_sequencer_tb.sv]
// Bench for the sequencer: registers, sleep, standby, watch, subactive, reset.
// Assumes the package, design, checker and reset model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module power_down_mode_sequencer_tb;
	import pdm_pkg::*;
	localparam int SC = 256;
	logic sys_clk = 1'b0, arst_n = 1'b0, wb_we_i = 1'b0, wb_sel_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, sleepExec = 1'b0, watchSelect = 1'b0;
	logic intMask = 1'b0, rstReq = 1'b0, sawWake = 1'b0, sawDir = 1'b0;
	logic [15:0] wb_adr_i = '0;
	logic [7:0] wb_dat_i = '0;
	logic [7:0] wb_dat_o, rd;
	logic wb_ack_o, reset_pin_n, sysClkRun, cpuSubclock, portsFloat, timerABase;
	logic wakeIntStart, directIntReq, cpuHalt, cpuReset, periphHalt;
	mode_e modeOut;
	wake_s wakeReq = '0;
	wake_s wakeEnable = wake_s'(4'hF);
	int badCount = 0, nCompared = 0;
	always #12.5 sys_clk = ~sys_clk;
	power_down_mode_sequencer #(.WAIT_SCALE(SC)) dut (.sys_clk, .arst_n, .wb_adr_i, .wb_dat_i,
		.wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleepExec,
		.watchSelect, .intMask, .wakeReq, .wakeEnable, .reset_pin_n, .sysClkRun, .cpuSubclock,
		.cpuHalt, .cpuReset, .periphHalt, .portsFloat, .timerABase, .wakeIntStart,
		.directIntReq, .modeOut);
	reset_pin_model rpm (.sys_clk, .rstReq, .modeOut, .reset_pin_n);
	always @(posedge sys_clk) begin
		if (wakeIntStart === 1'b1)
			sawWake = 1'b1;
		if (directIntReq === 1'b1)
			sawDir = 1'b1;
	end
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		nCompared++;
		if (g !== e) begin
			badCount++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [15:0] a, input logic [7:0] d, input logic w);
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_we_i <= w;
		wb_sel_i <= 1'b1;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge sys_clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic sl();
		sleepExec <= 1'b1;
		@(posedge sys_clk);
		sleepExec <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wk(input wake_s w);
		wakeReq <= w;
		repeat (2) @(posedge sys_clk);
		wakeReq <= '0;
	endtask
	task automatic rp();
		rstReq <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rstReq <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic settle(input int n);
		int k;
		k = 0;
		while (modeOut === M_SETTLE && k < 9000) begin
			@(posedge sys_clk);
			k++;
		end
		chk((k >= n - 1 && k <= n + 1) ? n : k, n);
	endtask
	task automatic t_regs();
		wb(ADDR_CTRL_ONE, 8'h00, 1'b0);
		chk(rd, 8'h00);
		wb(ADDR_CTRL_TWO, 8'h00, 1'b0);
		chk(rd, 8'hF4);
		wb(ADDR_CTRL_ONE, 8'hFF, 1'b1);
		wb(ADDR_CTRL_ONE, 8'h00, 1'b0);
		chk(rd, 8'hFC);
		wb(ADDR_CTRL_TWO, 8'h0B, 1'b1);
		wb(ADDR_CTRL_TWO, 8'h00, 1'b0);
		chk(rd, 8'hF7);
		wb(16'h0010, 8'hFF, 1'b1);
		wb(16'h0010, 8'h00, 1'b0);
		chk(rd, 8'h00);
	endtask
	task automatic t_sleep();
		wb(ADDR_CTRL_ONE, 8'h00, 1'b1);
		for (int i = 0; i < 3; i++) begin
			sl();
			chk(modeOut, M_SLEEP);
			intMask <= i == 0;
			wakeEnable <= (i == 0) ? wake_s'(4'hF) : wake_s'(4'h0);
			wakeReq <= wake_s'(4'h8 >> i);
			repeat (2) @(posedge sys_clk);
			chk(modeOut, M_SLEEP);
			sawWake = 1'b0;
			intMask <= 1'b0;
			wakeEnable <= wake_s'(4'hF);
			wk(wake_s'(4'h8 >> i));
			@(posedge sys_clk);
			chk(modeOut, M_ACTIVE);
			chk(sawWake, 1'b1);
		end
		sl();
		rp();
		chk(modeOut, M_RESET);
		chk({cpuReset, cpuHalt}, 2'h3);
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic t_standby();
		wb(ADDR_CTRL_ONE, 8'h80, 1'b1);
		wakeEnable <= wake_s'(4'hC);
		sl();
		chk(modeOut, M_STANDBY);
		chk({sysClkRun, portsFloat, cpuHalt, periphHalt}, 4'h7);
		wb(ADDR_CTRL_ONE, 8'h00, 1'b1);
		sawWake = 1'b0;
		wk(wake_s'(4'h4));
		chk(modeOut, M_SETTLE);
		settle(8192 / SC);
		wakeEnable <= wake_s'(4'hF);
		wb(ADDR_CTRL_ONE, 8'h00, 1'b0);
		chk(rd, 8'h80);
		chk({modeOut, sawWake}, {M_ACTIVE, 1'b1});
	endtask
	task automatic t_watch();
		wb(ADDR_CTRL_ONE, 8'h98, 1'b1);
		watchSelect <= 1'b1;
		sl();
		chk(modeOut, M_WATCH);
		wk(wake_s'(4'h2));
		chk(modeOut, M_SUBACT);
		chk({cpuHalt, periphHalt, cpuSubclock}, 3'h3);
		wb(ADDR_MODE, 8'h00, 1'b0);
		chk(rd, {5'h00, M_SUBACT});
		wb(ADDR_CTRL_TWO, 8'h00, 1'b1);
		sl();
		chk(modeOut, M_WATCH);
		wk(wake_s'(4'h2));
		wb(ADDR_CTRL_TWO, 8'h08, 1'b1);
		wb(ADDR_CTRL_TWO, 8'h00, 1'b0);
		chk(rd, 8'hFC);
		wb(ADDR_CTRL_ONE, 8'hA0, 1'b1);
		sl();
		chk(modeOut, M_SETTLE);
		settle(32768 / SC);
		chk({modeOut, sawDir}, {M_ACTIVE, 1'b1});
		watchSelect <= 1'b0;
	endtask
	task automatic t_reset();
		sl();
		rp();
		chk(modeOut, M_SETTLE);
		chk({cpuReset, sysClkRun}, 2'h2);
		settle(32768 / SC);
		chk(modeOut, M_RESET);
		chk({cpuReset, sysClkRun}, 2'h3);
		repeat (4) @(posedge sys_clk);
		chk(modeOut, M_ACTIVE);
	endtask
	task automatic giveVerdict();
		$display("compared %0d mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_regs();
		t_sleep();
		t_standby();
		t_watch();
		t_reset();
		giveVerdict();
	end
	initial begin
		#(25 * 40000);
		badCount++;
		giveVerdict();
	end
endmodule
`default_nettype wire
